// file: bench/tb_tsc_sensor_ctrl.sv
// Testbench: register access, conversion timing and alarm pins of the sensor control
`timescale 1ns/100ps
module tb_tsc_sensor_ctrl
  import tsc_pkg::*;
;
  // Shortened counts keep the run well under the cycle budget
  localparam int FC  = 200;
  localparam int CC  = 3000;
  localparam int SC  = 1000;
  localparam int SEC = 4000;
  logic        ref_clk;
  logic        reset;
  logic        sel_lo;
  logic        sel_hi;
  logic [15:0] temp;
  logic        scl;
  logic        sda;
  logic        sda_oe;
  logic        crit_oe;
  logic        lim_oe;
  logic [15:0] rv;
  logic        ok;
  int          fails;
  int          num_checks;

  tsc_sensor_ctrl #(
    .P_CONV_CYC(CC),
    .P_FAST_CYC(FC),
    .P_SPS_CYC (SC),
    .P_SEC_CYC (SEC)
  ) dut_u (
    .i_ref_clk              (ref_clk),
    .i_reset                (reset),
    .i_scl                  (scl),
    .i_sda                  (sda),
    .i_addr_select_low      (sel_lo),
    .i_addr_select_high     (sel_hi),
    .i_temp_sample          (temp),
    .o_sda_oe               (sda_oe),
    .o_critical_alarm_out_oe(crit_oe),
    .o_limit_alarm_oe       (lim_oe)
  );

  tsc_i2c_host host_u (
    .i_sda_oe(sda_oe),
    .o_scl   (scl),
    .o_sda   (sda)
  );

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    host_u.write_reg(ptr, d, ok);
    check("write ack", {15'h0, ok}, 16'h0001);
  endtask : wr

  task automatic alarms(input logic c, input logic l);
    check("critical alarm", {15'h0, crit_oe}, {15'h0, c});
    check("limit alarm", {15'h0, lim_oe}, {15'h0, l});
  endtask : alarms

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  initial begin
    fails = 0;
    num_checks = 0;
    reset = 1'b1;
    sel_lo = 1'b0;
    sel_hi = 1'b0;
    temp = 16'h4a07;
    tick(20);
    reset = 1'b0;
    tick(FC - 10);
    alarms(1'b0, 1'b0);
    tick(15);
    alarms(1'b1, 1'b1);
    host_u.read_pair(REG_TEMP_MSB, rv);
    check("temperature 13-bit", rv, 16'h4a00);
    host_u.read_pair(REG_CRIT_MSB, rv);
    check("critical limit", rv, 16'h4980);
    host_u.read_pair(REG_HIGH_MSB, rv);
    check("high limit", rv, HIGH_RESET);
    $display("test power-up done");
    // Sample changes only after the write, so an early result cannot pass
    wr(REG_SETUP, 8'h80);
    temp = 16'hff05;
    tick(CC - 300);
    alarms(1'b1, 1'b1);
    tick(310);
    alarms(1'b0, 1'b0);
    host_u.read_pair(REG_TEMP_MSB, rv);
    check("temperature 16-bit", rv, 16'hff05);
    $display("test resolution done");
    wr(REG_SETUP, 8'h98);
    tick(5);
    alarms(1'b1, 1'b1);
    wr(REG_SETUP, 8'h84);
    temp = 16'h3000;
    tick(CC + 10);
    alarms(1'b0, 1'b1);
    temp = 16'h4a00;
    tick(CC);
    alarms(1'b1, 1'b1);
    // Both alarms must stay latched through a cool sample until a read
    temp = 16'h0100;
    tick(CC);
    alarms(1'b1, 1'b1);
    host_u.read_pair(REG_TEMP_MSB, rv);
    check("temperature low", rv, 16'h0100);
    tick(5);
    alarms(1'b0, 1'b0);
    $display("test polarity and interrupt done");
    wr(REG_SETUP, 8'he0);
    temp = 16'h4a00;
    wr(REG_TEMP_MSB, 8'h55);
    tick(2 * CC);
    alarms(1'b0, 1'b0);
    host_u.read_pair(REG_TEMP_MSB, rv);
    check("held temperature", rv, 16'h0100);
    $display("test shutdown done");
    wr(REG_SETUP, 8'hc0);
    tick(SC - 200);
    alarms(1'b0, 1'b0);
    tick(210);
    alarms(1'b1, 1'b1);
    temp = 16'hff05;
    tick(SEC - SC - 300);
    alarms(1'b1, 1'b1);
    tick(SC + 300);
    alarms(1'b0, 1'b0);
    $display("test one per second done");
    wr(REG_SETUP, 8'ha0);
    temp = 16'h4a00;
    tick(CC + 10);
    alarms(1'b1, 1'b1);
    temp = 16'hff05;
    tick(CC + 100);
    alarms(1'b1, 1'b1);
    host_u.read_pair(8'h02, rv);
    check("unmapped and setup", rv, {8'h00, 8'he0});
    $display("test one-shot done");
    for (int s = 0; s < 4; s++) begin
      {sel_hi, sel_lo} = s[1:0];
      tick(10);
      host_u.probe(BUS_ADDR_BASE | 7'(s), ok);
      check("own address", {15'h0, ok}, 16'h0001);
      host_u.probe(BUS_ADDR_BASE | 7'(s ^ 1), ok);
      check("other address", {15'h0, ok}, 16'h0000);
    end
    $display("test address select done");
    end_of_test();
  end

  // Roughly twice the expected run length
  initial begin
    repeat (70000) @(posedge ref_clk);
    fails++;
    end_of_test();
  end
endmodule : tb_tsc_sensor_ctrl

// file: bench/tsc_i2c_host.sv
// Bus host model: open-drain two-wire master that sets up and reads the sensor
`timescale 1ns/100ps
module tsc_i2c_host (
  input  wire logic i_sda_oe,
  output logic      o_scl,
  output logic      o_sda
);
  // Quarter of the 80 ns link clock; the pin filter lag uses up most of each low phase
  localparam int QTR = 20;
  logic       scl_drv = 1'b1;
  logic       sda_drv = 1'b1;
  logic [6:0] dev_addr = 7'h48;

  // Pull-ups win wherever nobody pulls low
  assign o_scl = scl_drv;
  assign o_sda = sda_drv & ~i_sda_oe;

  task automatic bit_io(input logic b, output logic r);
    sda_drv = b;
    #QTR;
    scl_drv = 1'b1;
    #QTR;
    r = o_sda;
    #QTR;
    scl_drv = 1'b0;
    #QTR;
  endtask : bit_io

  task automatic start_cond();
    sda_drv = 1'b1;
    #QTR;
    scl_drv = 1'b1;
    #QTR;
    sda_drv = 1'b0;
    #QTR;
    scl_drv = 1'b0;
    #QTR;
  endtask : start_cond

  task automatic stop_cond();
    sda_drv = 1'b0;
    #QTR;
    scl_drv = 1'b1;
    #QTR;
    sda_drv = 1'b1;
    #QTR;
  endtask : stop_cond

  task automatic tx_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : tx_byte

  task automatic rx_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 0; i < 8; i++) begin
      bit_io(1'b1, r);
      d = {d[6:0], r};
    end
    bit_io(last, r);
  endtask : rx_byte

  task automatic write_reg(input logic [7:0] ptr, input logic [7:0] d, output logic ok);
    logic a0;
    logic a1;
    logic a2;
    start_cond();
    tx_byte({dev_addr, 1'b0}, a0);
    tx_byte(ptr, a1);
    tx_byte(d, a2);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask : write_reg

  task automatic read_pair(input logic [7:0] ptr, output logic [15:0] v);
    logic       a0;
    logic [7:0] hi;
    logic [7:0] lo;
    start_cond();
    tx_byte({dev_addr, 1'b0}, a0);
    tx_byte(ptr, a0);
    stop_cond();
    start_cond();
    tx_byte({dev_addr, 1'b1}, a0);
    rx_byte(1'b0, hi);
    rx_byte(1'b1, lo);
    stop_cond();
    v = {hi, lo};
  endtask : read_pair

  task automatic probe(input logic [6:0] a, output logic ack);
    start_cond();
    tx_byte({a, 1'b0}, ack);
    stop_cond();
  endtask : probe
endmodule : tsc_i2c_host

// file: hw/tsc_bus_target.sv
// Two-wire bus target: pin filtering, address match, register pointer and byte transfers
`timescale 1ns/100ps
module tsc_bus_target
  import tsc_pkg::*;
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_reset,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  input  wire logic [6:0] i_dev_addr,
  input  wire logic [7:0] i_rd_data,
  output logic            o_sda_oe,
  output logic            o_wr_strobe,
  output logic            o_rd_strobe,
  output logic [7:0]      o_reg_addr,
  output logic [7:0]      o_wr_data
);
  typedef struct packed {
    logic [SYNC_W-1:0] scl_sync;
    logic [SYNC_W-1:0] sda_sync;
    logic              scl;
    logic              sda;
    tsc_bus_state_t    st;
    logic [3:0]        bitcnt;
    logic [7:0]        shreg;
    logic              rw;
    logic              ptr_pending;
    logic              nack;
    logic [7:0]        ptr;
    logic              sda_oe;
    logic              wr_stb;
    logic              rd_stb;
  } tsc_bus_core_t;

  tsc_bus_core_t r_reg;
  tsc_bus_core_t r_next;
  logic          rise;
  logic          fall;

  always_comb begin
    r_next          = r_reg;
    r_next.wr_stb   = 1'b0;
    r_next.rd_stb   = 1'b0;
    r_next.scl_sync = {r_reg.scl_sync[SYNC_W-2:0], i_scl};
    r_next.sda_sync = {r_reg.sda_sync[SYNC_W-2:0], i_sda};
    // A level counts only once the last two stages agree
    if (r_reg.scl_sync[1] == r_reg.scl_sync[2]) begin
      r_next.scl = r_reg.scl_sync[2];
    end
    if (r_reg.sda_sync[1] == r_reg.sda_sync[2]) begin
      r_next.sda = r_reg.sda_sync[2];
    end
    rise = !r_reg.scl && r_next.scl;
    fall = r_reg.scl && !r_next.scl;
    if (r_reg.wr_stb || r_reg.rd_stb) begin
      r_next.ptr = r_reg.ptr + 8'h01;
    end
    if (r_reg.scl && r_next.scl && r_reg.sda && !r_next.sda) begin
      r_next.st          = BS_ADDR;
      r_next.bitcnt      = 4'h0;
      r_next.sda_oe      = 1'b0;
      r_next.ptr_pending = 1'b1;
    end else if (r_reg.scl && r_next.scl && !r_reg.sda && r_next.sda) begin
      r_next.st     = BS_IDLE;
      r_next.sda_oe = 1'b0;
    end else begin
      case (r_reg.st)
        BS_IDLE: begin
          r_next.sda_oe = 1'b0;
        end
        BS_ADDR, BS_WDATA: begin
          if (rise && r_reg.bitcnt != 4'h8) begin
            r_next.shreg  = {r_reg.shreg[6:0], r_next.sda};
            r_next.bitcnt = r_reg.bitcnt + 4'h1;
          end
          if (fall && r_reg.bitcnt == 4'h8) begin
            r_next.bitcnt = 4'h0;
            if (r_reg.st == BS_ADDR) begin
              if (r_reg.shreg[7:1] == i_dev_addr) begin
                r_next.sda_oe = 1'b1;
                r_next.rw     = r_reg.shreg[0];
                r_next.st     = BS_ACK_A;
              end else begin
                r_next.st = BS_IDLE;
              end
            end else begin
              r_next.sda_oe = 1'b1;
              r_next.st     = BS_ACK_W;
              // First data byte of a write is the register pointer
              if (r_reg.ptr_pending) begin
                r_next.ptr         = r_reg.shreg;
                r_next.ptr_pending = 1'b0;
              end else begin
                r_next.wr_stb = 1'b1;
              end
            end
          end
        end
        BS_ACK_A, BS_ACK_R: begin
          if (rise) begin
            r_next.nack = r_next.sda;
          end
          if (fall) begin
            if ((r_reg.st == BS_ACK_A && r_reg.rw) || (r_reg.st == BS_ACK_R && !r_reg.nack)) begin
              r_next.shreg  = i_rd_data;
              r_next.sda_oe = !i_rd_data[7];
              r_next.st     = BS_RDATA;
            end else begin
              r_next.sda_oe = 1'b0;
              r_next.st     = (r_reg.st == BS_ACK_A) ? BS_WDATA : BS_IDLE;
            end
          end
        end
        BS_ACK_W: begin
          if (fall) begin
            r_next.sda_oe = 1'b0;
            r_next.st     = BS_WDATA;
          end
        end
        BS_RDATA: begin
          if (rise) begin
            r_next.bitcnt = r_reg.bitcnt + 4'h1;
          end
          if (fall) begin
            if (r_reg.bitcnt == 4'h8) begin
              r_next.bitcnt = 4'h0;
              r_next.sda_oe = 1'b0;
              r_next.rd_stb = 1'b1;
              r_next.st     = BS_ACK_R;
            end else begin
              r_next.shreg  = {r_reg.shreg[6:0], 1'b0};
              r_next.sda_oe = !r_reg.shreg[6];
            end
          end
        end
        default: begin
          r_next.st = BS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      r_reg <= '{scl_sync: '1, sda_sync: '1, scl: 1'b1, sda: 1'b1, st: BS_IDLE, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_sda_oe    = r_reg.sda_oe;
  assign o_wr_strobe = r_reg.wr_stb;
  assign o_rd_strobe = r_reg.rd_stb;
  assign o_reg_addr  = r_reg.ptr;
  assign o_wr_data   = r_reg.shreg;

  a_addr_ack: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (r_reg.st == BS_ADDR && fall && r_reg.bitcnt == 4'h8 && r_reg.shreg[7:1] == i_dev_addr)
      |=> (o_sda_oe && r_reg.st == BS_ACK_A))
    else $error("matching address not acknowledged");
  a_ptr_advance: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (o_wr_strobe && r_reg.st == BS_ACK_W) |=> (o_reg_addr == $past(o_reg_addr) + 8'h01))
    else $error("register pointer did not advance after a write");
endmodule : tsc_bus_target

// file: hw/tsc_pkg.sv
// Shared constants, register map and state encodings for the temperature sensor control
package tsc_pkg;
  localparam int CLK_HZ     = 100_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int CONV_MS    = 240;
  localparam int FAST_MS    = 6;
  localparam int SPS_MS     = 60;
  localparam int SEC_MS     = 1000;
  localparam int CONV_CYC   = CONV_MS * CYC_PER_MS;
  localparam int FAST_CYC   = FAST_MS * CYC_PER_MS;
  localparam int SPS_CYC    = SPS_MS * CYC_PER_MS;
  localparam int SEC_CYC    = SEC_MS * CYC_PER_MS;
  localparam int CNT_W      = 27;
  localparam int SYNC_W     = 3;

  localparam logic [7:0] REG_TEMP_MSB = 8'h00;
  localparam logic [7:0] REG_TEMP_LSB = 8'h01;
  localparam logic [7:0] REG_SETUP    = 8'h03;
  localparam logic [7:0] REG_HIGH_MSB = 8'h04;
  localparam logic [7:0] REG_HIGH_LSB = 8'h05;
  localparam logic [7:0] REG_CRIT_MSB = 8'h08;
  localparam logic [7:0] REG_CRIT_LSB = 8'h09;

  localparam int SETUP_RES      = 7;
  localparam int SETUP_MODE_HI  = 6;
  localparam int SETUP_MODE_LO  = 5;
  localparam int SETUP_CRIT_POL = 4;
  localparam int SETUP_LIM_POL  = 3;
  localparam int SETUP_INT_MODE = 2;

  localparam logic [7:0]  SETUP_RESET = 8'h00;
  localparam logic [15:0] CRIT_RESET  = 16'h4980;
  localparam logic [15:0] HIGH_RESET  = 16'h2000;
  localparam logic [15:0] RES13_MASK  = 16'hfff8;
  localparam logic [6:0]  BUS_ADDR_BASE = 7'h48;

  localparam logic [1:0] MODE_CONT    = 2'h0;
  localparam logic [1:0] MODE_ONESHOT = 2'h1;
  localparam logic [1:0] MODE_SPS     = 2'h2;
  localparam logic [1:0] MODE_SHUT    = 2'h3;

  typedef enum logic [3:0] {
    CV_FIRST = 4'b0001,
    CV_CONV  = 4'b0010,
    CV_IDLE  = 4'b0100,
    CV_SHUT  = 4'b1000
  } tsc_conv_state_t;

  typedef enum logic [6:0] {
    BS_IDLE  = 7'b0000001,
    BS_ADDR  = 7'b0000010,
    BS_ACK_A = 7'b0000100,
    BS_WDATA = 7'b0001000,
    BS_ACK_W = 7'b0010000,
    BS_RDATA = 7'b0100000,
    BS_ACK_R = 7'b1000000
  } tsc_bus_state_t;
endpackage : tsc_pkg

// file: hw/tsc_sensor_ctrl.sv
// Temperature sensor control: conversion timing, result format, alarms and register file
// What this block does
// - After reset results are 13-bit with 0.0625 degree steps until software changes it.
// - Writing setup register 0x03 bit 7 to one selects 16-bit results with 0.0078 degree steps.
// - A 13-bit result is two's complement, a sign bit and twelve magnitude bits.
// - A 16-bit result is two's complement, a sign bit and fifteen magnitude bits.
// - The bus address is one of four, picked by the two address-select pins.
// - The critical alarm output goes active when the temperature rises above the critical limit.
// - The critical limit holds 147 degrees until software reprograms it.
// - The second alarm output goes active when the temperature rises above a separate limit.
// - Each alarm runs in comparator or interrupt mode, chosen by software.
// - Shutdown mode stops all conversion until another mode is written.
// - A power-saving mode performs one conversion per second.
// - The first conversion after reset finishes in 6 ms.
// - Continuous and one-shot conversions take 240 ms each.
// - In one-per-second mode a conversion takes 60 ms and the rest of the second is idle.
`timescale 1ns/100ps
module tsc_sensor_ctrl
  import tsc_pkg::*;
#(
  parameter int P_CONV_CYC = CONV_CYC,
  parameter int P_FAST_CYC = FAST_CYC,
  parameter int P_SPS_CYC  = SPS_CYC,
  parameter int P_SEC_CYC  = SEC_CYC
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  input  wire logic        i_addr_select_low,
  input  wire logic        i_addr_select_high,
  input  wire logic [15:0] i_temp_sample,
  output logic             o_sda_oe,
  output logic             o_critical_alarm_out_oe,
  output logic             o_limit_alarm_oe
);
  typedef struct packed {
    logic [SYNC_W-1:0] lo_sync;
    logic [SYNC_W-1:0] hi_sync;
    logic [1:0]        sel;
    tsc_conv_state_t   st;
    logic [CNT_W-1:0]  cnt;
    logic [7:0]        setup;
    logic [15:0]       crit;
    logic [15:0]       high;
    logic [15:0]       temp;
    logic              crit_act;
    logic              lim_act;
    logic              crit_oe;
    logic              lim_oe;
    logic              crit_touched;
  } tsc_core_t;

  tsc_core_t   r_reg;
  tsc_core_t   r_next;
  logic        wr_strobe;
  logic        rd_strobe;
  logic [7:0]  reg_addr;
  logic [7:0]  wr_data;
  logic [7:0]  rd_data;
  logic [1:0]  mode;
  logic        int_mode;
  logic        done;
  logic [15:0] result;
  logic        crit_hit;
  logic        lim_hit;

  // Coarse mode clears the three finest bits so that sign plus twelve remain
  function automatic logic [15:0] fmt_result(input logic [15:0] raw, input logic res16);
    fmt_result = res16 ? raw : (raw & RES13_MASK);
  endfunction : fmt_result

  function automatic logic [CNT_W-1:0] last_cyc(input int cycles);
    last_cyc = CNT_W'(cycles - 1);
  endfunction : last_cyc

  function automatic logic [7:0] read_mux(input logic [7:0] addr, input tsc_core_t s);
    case (addr)
      REG_TEMP_MSB: read_mux = s.temp[15:8];
      REG_TEMP_LSB: read_mux = s.temp[7:0];
      REG_SETUP:    read_mux = s.setup;
      REG_HIGH_MSB: read_mux = s.high[15:8];
      REG_HIGH_LSB: read_mux = s.high[7:0];
      REG_CRIT_MSB: read_mux = s.crit[15:8];
      REG_CRIT_LSB: read_mux = s.crit[7:0];
      default:      read_mux = 8'h00;
    endcase
  endfunction : read_mux

  assign rd_data = read_mux(reg_addr, r_reg);

  tsc_bus_target u_bus (
    .i_ref_clk   (i_ref_clk),
    .i_reset     (i_reset),
    .i_scl       (i_scl),
    .i_sda       (i_sda),
    .i_dev_addr  (BUS_ADDR_BASE | {5'h00, r_reg.sel}),
    .i_rd_data   (rd_data),
    .o_sda_oe    (o_sda_oe),
    .o_wr_strobe (wr_strobe),
    .o_rd_strobe (rd_strobe),
    .o_reg_addr  (reg_addr),
    .o_wr_data   (wr_data)
  );

  always_comb begin
    r_next         = r_reg;
    r_next.lo_sync = {r_reg.lo_sync[SYNC_W-2:0], i_addr_select_low};
    r_next.hi_sync = {r_reg.hi_sync[SYNC_W-2:0], i_addr_select_high};
    if (r_reg.lo_sync[1] == r_reg.lo_sync[2]) begin
      r_next.sel[0] = r_reg.lo_sync[2];
    end
    if (r_reg.hi_sync[1] == r_reg.hi_sync[2]) begin
      r_next.sel[1] = r_reg.hi_sync[2];
    end
    mode     = r_reg.setup[SETUP_MODE_HI:SETUP_MODE_LO];
    int_mode = r_reg.setup[SETUP_INT_MODE];
    done     = (r_reg.st == CV_FIRST && r_reg.cnt == last_cyc(P_FAST_CYC))
            || (r_reg.st == CV_CONV && mode == MODE_SPS && r_reg.cnt == last_cyc(P_SPS_CYC))
            || (r_reg.st == CV_CONV && mode != MODE_SPS && r_reg.cnt == last_cyc(P_CONV_CYC));
    result   = fmt_result(i_temp_sample, r_reg.setup[SETUP_RES]);
    crit_hit = $signed(result) > $signed(r_reg.crit);
    lim_hit  = $signed(result) > $signed(r_reg.high);
    r_next.cnt = r_reg.cnt + CNT_W'(1);

    case (r_reg.st)
      CV_FIRST, CV_CONV: begin
        if (done) begin
          r_next.cnt  = '0;
          r_next.temp = result;
          case (mode)
            MODE_SPS:     r_next.st = CV_IDLE;
            MODE_SHUT:    r_next.st = CV_SHUT;
            MODE_ONESHOT: begin
              r_next.st = CV_SHUT;
              r_next.setup[SETUP_MODE_HI:SETUP_MODE_LO] = MODE_SHUT;
            end
            default:      r_next.st = CV_CONV;
          endcase
        end
      end
      CV_IDLE: begin
        if (r_reg.cnt == last_cyc(P_SEC_CYC - P_SPS_CYC)) begin
          r_next.cnt = '0;
          r_next.st  = CV_CONV;
        end
      end
      CV_SHUT: begin
        r_next.cnt = '0;
      end
      default: begin
        r_next.st  = CV_FIRST;
        r_next.cnt = '0;
      end
    endcase

    // Interrupt mode latches until a register read; a new crossing wins over the read
    if (int_mode && rd_strobe) begin
      r_next.crit_act = 1'b0;
      r_next.lim_act  = 1'b0;
    end
    if (done) begin
      if (int_mode) begin
        r_next.crit_act = r_next.crit_act | crit_hit;
        r_next.lim_act  = r_next.lim_act | lim_hit;
      end else begin
        r_next.crit_act = crit_hit;
        r_next.lim_act  = lim_hit;
      end
    end

    if (wr_strobe) begin
      case (reg_addr)
        REG_SETUP: begin
          r_next.setup = wr_data;
          r_next.cnt   = '0;
          // Any mode write restarts timing so a new mode takes effect at once
          r_next.st = (wr_data[SETUP_MODE_HI:SETUP_MODE_LO] == MODE_SHUT) ? CV_SHUT : CV_CONV;
        end
        REG_HIGH_MSB: r_next.high[15:8] = wr_data;
        REG_HIGH_LSB: r_next.high[7:0]  = wr_data;
        REG_CRIT_MSB: begin
          r_next.crit[15:8]   = wr_data;
          r_next.crit_touched = 1'b1;
        end
        REG_CRIT_LSB: begin
          r_next.crit[7:0]    = wr_data;
          r_next.crit_touched = 1'b1;
        end
        default: begin
          r_next.crit_touched = r_reg.crit_touched;
        end
      endcase
    end

    // Pin enable lags the alarm state by one cycle
    r_next.crit_oe = r_reg.crit_act ^ r_reg.setup[SETUP_CRIT_POL];
    r_next.lim_oe  = r_reg.lim_act ^ r_reg.setup[SETUP_LIM_POL];
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      r_reg <= '{st: CV_FIRST, setup: SETUP_RESET, crit: CRIT_RESET, high: HIGH_RESET, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_critical_alarm_out_oe = r_reg.crit_oe;
  assign o_limit_alarm_oe        = r_reg.lim_oe;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_reset);

  a_coarse_format: assert property (done && !r_reg.setup[SETUP_RES]
    |=> (r_reg.temp[2:0] == 3'h0 && r_reg.temp[15:3] == $past(i_temp_sample[15:3])))
    else $error("13-bit result not sign plus twelve bits");
  a_fine_format: assert property (done && r_reg.setup[SETUP_RES]
    |=> r_reg.temp == $past(i_temp_sample))
    else $error("16-bit result does not carry all sixteen bits");
  a_crit_compare: assert property (done && !int_mode
    |=> r_reg.crit_act == ($signed($past(result)) > $signed($past(r_reg.crit))))
    else $error("critical alarm disagrees with comparison");
  a_crit_default: assert property (!r_reg.crit_touched |-> r_reg.crit == 16'h4980)
    else $error("critical limit changed without a write");
  a_limit_compare: assert property (done && lim_hit |=> r_reg.lim_act)
    else $error("limit alarm missed a crossing");
  a_int_latch: assert property (int_mode && r_reg.crit_act && !rd_strobe && !wr_strobe
    |=> r_reg.crit_act)
    else $error("interrupt-mode alarm dropped without a read");
  a_shut_hold: assert property (r_reg.st == CV_SHUT && !wr_strobe
    |=> (r_reg.st == CV_SHUT && r_reg.temp == $past(r_reg.temp)))
    else $error("conversion activity during shutdown");
  a_sps_idle: assert property (done && mode == MODE_SPS && r_reg.st == CV_CONV && !wr_strobe
    |-> (r_reg.cnt == last_cyc(P_SPS_CYC)) ##1 (r_reg.st == CV_IDLE))
    else $error("one-per-second conversion length or idle wrong");
  a_first_fast: assert property (r_reg.st == CV_FIRST && done |-> r_reg.cnt == last_cyc(P_FAST_CYC))
    else $error("first conversion not the fast length");
  a_conv_len: assert property (done && r_reg.st == CV_CONV && mode == MODE_CONT
    |-> r_reg.cnt == CNT_W'(P_CONV_CYC - 1))
    else $error("continuous conversion length wrong");
  a_pin_polarity: assert property (##1 1'b1 |-> o_critical_alarm_out_oe
    == ($past(r_reg.crit_act) ^ $past(r_reg.setup[SETUP_CRIT_POL])))
    else $error("critical pin enable does not follow alarm and polarity");
  a_setup_write: assert property (wr_strobe && reg_addr == REG_SETUP |=> r_reg.setup == $past(wr_data))
    else $error("setup register write lost");

  c_first_done: cover property (r_reg.st == CV_FIRST ##1 r_reg.st == CV_CONV);
  c_sps_cycle: cover property (r_reg.st == CV_IDLE ##1 r_reg.st == CV_CONV);
  c_crit_alarm: cover property ($rose(o_critical_alarm_out_oe));
  c_oneshot: cover property (done && mode == MODE_ONESHOT);
endmodule : tsc_sensor_ctrl
